/* File: rtl/pgm_map.svh */
`ifndef PGM_MAP_SVH
`define PGM_MAP_SVH

// Command code of the configuration register
`define PGM_CMD_GEN_MASK      8'h17
// Command codes of the priority settings that the shutdown logic follows
`define PGM_CMD_PRIO_1BIT     8'h15
`define PGM_CMD_PRIO_3BIT_A   8'h27
`define PGM_CMD_PRIO_3BIT_B   8'h28

// Field positions
`define PGM_BIT_IRQ_GATE      7
`define PGM_BIT_WIDE_ACCESS   5
`define PGM_BIT_MULTI_LEVEL   4
`define PGM_BIT_CLASS_CHG     3
`define PGM_BIT_DETECT_CHG    2

// Reset value: only the interrupt gate is set
`define PGM_GEN_MASK_RESET    8'h80

// Shutdown input must idle low this long before multi-level mode is entered
`define PGM_SHUT_IDLE_US      200
`define PGM_CLK_MHZ           125
`define PGM_SHUT_IDLE_CYC     (`PGM_SHUT_IDLE_US * `PGM_CLK_MHZ)

`endif

/* File: rtl/pgm_pkg.sv */
package pgm_pkg;
    typedef logic [7:0] pgm_byte_t;
    typedef logic [3:0] pgm_chan4_t;
    typedef logic [1:0] pgm_result_t;
endpackage

/* File: rtl/pgm_event_chan.sv */
`timescale 1ns/1ps
`include "pgm_map.svh"

// One channel: detection and classification event flags
module pgm_event_chan
    import pgm_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Mode selects
    input  wire logic        class_change_only_i,
    input  wire logic        detect_change_only_i,
    // Cycle completions with results
    input  wire logic        class_done_i,
    input  wire logic [3:0]  class_result_i,
    input  wire logic        detect_done_i,
    input  wire logic [3:0]  detect_result_i,
    // Flag clear from event register read
    input  wire logic        clear_i,
    // Flags
    output logic             class_event_flag_o,
    output logic             detect_event_flag_o
);
    logic [3:0] class_prev_q, class_prev_d;
    logic [3:0] det_prev_q,   det_prev_d;
    logic       cls_q,        cls_d;
    logic       det_q,        det_d;
    logic       cls_set, det_set;

    always_comb begin
        cls_set      = class_done_i &&
                       (!class_change_only_i || class_result_i != class_prev_q);
        det_set      = detect_done_i &&
                       (!detect_change_only_i || detect_result_i != det_prev_q);
        class_prev_d = class_done_i ? class_result_i : class_prev_q;
        det_prev_d   = detect_done_i ? detect_result_i : det_prev_q;
        // Set wins over a clear in the same cycle
        cls_d        = cls_set || (cls_q && !clear_i);
        det_d        = det_set || (det_q && !clear_i);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            class_prev_q <= 4'h0;
            det_prev_q   <= 4'h0;
            cls_q        <= 1'b0;
            det_q        <= 1'b0;
        end else begin
            class_prev_q <= class_prev_d;
            det_prev_q   <= det_prev_d;
            cls_q        <= cls_d;
            det_q        <= det_d;
        end
    end

    assign class_event_flag_o  = cls_q;
    assign detect_event_flag_o = det_q;

    a_cls_every_cycle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        class_done_i && !class_change_only_i |=> class_event_flag_o)
        else $error("class flag not set after class cycle");
    a_det_same_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        detect_done_i && detect_change_only_i && detect_result_i == det_prev_q
        && !det_q |=> !detect_event_flag_o)
        else $error("detect flag set with unchanged result");
endmodule // pgm_event_chan

/* File: rtl/pgm_general_mask.sv */
`timescale 1ns/1ps
`include "pgm_map.svh"

// What this block does
// - Global interrupt gate cleared keeps the interrupt pin inactive always.
// - Gate only affects the pin, never event register contents.
// - Wide access set: one bus address, bus_addr_lsb zero, 16-bit transfers.
// - Wide access clear: two four-channel devices, consecutive addresses, 8-bit.
// - Multi-level set: 3-bit priority from settings at 0x27 and 0x28.
// - Multi-level clear: 1-bit priority from setting at 0x15.
// - Class change only set: class flag only on changed result.
// - Detect change only set: detect flag only on changed result.
// - Register is command 17h, one data byte, read and write.
module pgm_general_mask
    import pgm_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Decoded command port from the serial bus engine
    input  wire logic        cmd_wr_i,
    input  wire logic        cmd_rd_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [7:0]  cmd_wdata_i,
    output logic      [7:0]  cmd_rdata_o,
    output logic             cmd_hit_o,
    // Interrupt sources and per-bit masks
    input  wire logic [7:0]  irq_status_i,
    input  wire logic [7:0]  irq_mask_i,
    output logic             irq_n_o,
    // Access configuration
    input  wire logic        bus_addr_lsb_i,
    output logic             wide_access_sel_o,
    output logic             bus_addr_lsb_o,
    // Shutdown priority selection
    input  wire logic        fast_shutdown_in_i,
    output logic             multi_level_shutdown_sel_o,
    output logic [7:0]       prio_cmd_a_o,
    output logic [7:0]       prio_cmd_b_o,
    output logic             shut_idle_ok_o,
    // Per-channel detect and class events
    input  wire logic [3:0]  class_done_i,
    input  wire logic [15:0] class_result_i,
    input  wire logic [3:0]  detect_done_i,
    input  wire logic [15:0] detect_result_i,
    input  wire logic        event_clear_i,
    output logic [3:0]       class_event_flag_o,
    output logic [3:0]       detect_event_flag_o
);
    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    pgm_byte_t  gm_q, gm_d;
    logic [7:0] rdata_q, rdata_d;
    logic       hit_q, hit_d;
    logic       reg_sel;

    always_comb begin
        reg_sel = (cmd_code_i == `PGM_CMD_GEN_MASK);
        gm_d    = gm_q;
        if (cmd_wr_i && reg_sel) begin
            gm_d = cmd_wdata_i;
        end
        rdata_d = (cmd_rd_i && reg_sel) ? gm_q : 8'h00;
        hit_d   = (cmd_rd_i || cmd_wr_i) && reg_sel;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            gm_q    <= `PGM_GEN_MASK_RESET;
            rdata_q <= 8'h00;
            hit_q   <= 1'b0;
        end else begin
            gm_q    <= gm_d;
            rdata_q <= rdata_d;
            hit_q   <= hit_d;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] shut_sync_q, shut_sync_d;
    logic [1:0] a0_sync_q, a0_sync_d;

    always_comb begin
        shut_sync_d = {shut_sync_q[0], fast_shutdown_in_i};
        a0_sync_d   = {a0_sync_q[0], bus_addr_lsb_i};
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            shut_sync_q <= 2'h0;
            a0_sync_q   <= 2'h0;
        end else begin
            shut_sync_q <= shut_sync_d;
            a0_sync_q   <= a0_sync_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Idle count is a status hint only; the host owns the 200 us wait
    localparam int unsigned IDLE_CYC = `PGM_SHUT_IDLE_CYC;
    logic [15:0] idle_cnt_q, idle_cnt_d;
    logic        irq_n_q, irq_n_d;
    logic        wide_q, wide_d;
    logic        a0_q, a0_d;
    logic        ml_q, ml_d;
    logic [7:0]  pa_q, pa_d, pb_q, pb_d;
    logic        idle_q, idle_d;

    always_comb begin
        // Events are untouched here; only the pin is gated
        irq_n_d = !(gm_q[`PGM_BIT_IRQ_GATE] && |(irq_status_i & ~irq_mask_i));
        wide_d  = gm_q[`PGM_BIT_WIDE_ACCESS];
        // Wide mode answers only at the even address
        a0_d    = gm_q[`PGM_BIT_WIDE_ACCESS] ? 1'b0 : a0_sync_q[1];
        ml_d    = gm_q[`PGM_BIT_MULTI_LEVEL];
        if (gm_q[`PGM_BIT_MULTI_LEVEL]) begin
            pa_d = `PGM_CMD_PRIO_3BIT_A;
            pb_d = `PGM_CMD_PRIO_3BIT_B;
        end else begin
            pa_d = `PGM_CMD_PRIO_1BIT;
            pb_d = `PGM_CMD_PRIO_1BIT;
        end
        if (shut_sync_q[1]) begin
            idle_cnt_d = 16'h0000;
        end else if (idle_cnt_q < 16'(IDLE_CYC)) begin
            idle_cnt_d = idle_cnt_q + 16'h0001;
        end else begin
            idle_cnt_d = idle_cnt_q;
        end
        idle_d = (idle_cnt_q >= 16'(IDLE_CYC));
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_n_q    <= 1'b1;
            wide_q     <= 1'b0;
            a0_q       <= 1'b0;
            ml_q       <= 1'b0;
            pa_q       <= `PGM_CMD_PRIO_1BIT;
            pb_q       <= `PGM_CMD_PRIO_1BIT;
            idle_cnt_q <= 16'h0000;
            idle_q     <= 1'b0;
        end else begin
            irq_n_q    <= irq_n_d;
            wide_q     <= wide_d;
            a0_q       <= a0_d;
            ml_q       <= ml_d;
            pa_q       <= pa_d;
            pb_q       <= pb_d;
            idle_cnt_q <= idle_cnt_d;
            idle_q     <= idle_d;
        end
    end

    assign cmd_rdata_o                = rdata_q;
    assign cmd_hit_o                  = hit_q;
    assign irq_n_o                    = irq_n_q;
    assign wide_access_sel_o          = wide_q;
    assign bus_addr_lsb_o             = a0_q;
    assign multi_level_shutdown_sel_o = ml_q;
    assign prio_cmd_a_o               = pa_q;
    assign prio_cmd_b_o               = pb_q;
    assign shut_idle_ok_o             = idle_q;

    // ------------------------------------------------------------
    // Event channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < 4; c++) begin : g_chan
        pgm_event_chan u_chan (
            .sys_clk_i            (sys_clk_i),
            .rst_i                (rst_i),
            .class_change_only_i  (gm_q[`PGM_BIT_CLASS_CHG]),
            .detect_change_only_i (gm_q[`PGM_BIT_DETECT_CHG]),
            .class_done_i         (class_done_i[c]),
            .class_result_i       (class_result_i[4*c +: 4]),
            .detect_done_i        (detect_done_i[c]),
            .detect_result_i      (detect_result_i[4*c +: 4]),
            .clear_i              (event_clear_i),
            .class_event_flag_o   (class_event_flag_o[c]),
            .detect_event_flag_o  (detect_event_flag_o[c])
        );
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_irq_gate_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !gm_q[`PGM_BIT_IRQ_GATE] |=> irq_n_o)
        else $error("interrupt pin active while gate off");
    a_irq_unmasked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        gm_q[`PGM_BIT_IRQ_GATE] && |(irq_status_i & ~irq_mask_i) |=> !irq_n_o)
        else $error("unmasked interrupt did not reach pin");
    a_wide_addr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        gm_q[`PGM_BIT_WIDE_ACCESS] |=> wide_access_sel_o && !bus_addr_lsb_o)
        else $error("wide access not reflected");
    a_narrow_mode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !gm_q[`PGM_BIT_WIDE_ACCESS] |=> !wide_access_sel_o)
        else $error("narrow access not reflected");
    a_prio_multi: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        gm_q[`PGM_BIT_MULTI_LEVEL] |=> prio_cmd_a_o == 8'h27 && prio_cmd_b_o == 8'h28)
        else $error("multi-level priority source wrong");
    a_prio_single: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !gm_q[`PGM_BIT_MULTI_LEVEL] |=> prio_cmd_a_o == 8'h15 && prio_cmd_b_o == 8'h15)
        else $error("single-level priority source wrong");
    a_reg_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cmd_wr_i && cmd_code_i == 8'h17 ##1 cmd_rd_i && cmd_code_i == 8'h17
        |=> cmd_rdata_o == $past(cmd_wdata_i, 2) && cmd_hit_o)
        else $error("register readback mismatch");
    a_gate_events: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $changed(gm_q[`PGM_BIT_IRQ_GATE]) && !event_clear_i && class_done_i == 4'h0
        |=> class_event_flag_o == $past(class_event_flag_o))
        else $error("gate change disturbed events");
endmodule // pgm_general_mask

/* File: dv/pgm_host.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Host side of the decoded command port
// ----------------------------------------
module pgm_host (
    // Clock and read data
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] cmd_rdata_i,
    // Command strobes
    output logic            cmd_wr_o,
    output logic            cmd_rd_o,
    output logic [7:0]      cmd_code_o,
    output logic [7:0]      cmd_wdata_o,
    // Shutdown stream
    output logic            fast_shutdown_in_o
);
    initial begin
        cmd_wr_o           = 1'b0;
        cmd_rd_o           = 1'b0;
        cmd_code_o         = 8'h00;
        cmd_wdata_o        = 8'h00;
        fast_shutdown_in_o = 1'b1;
    end

    // Idle fields flip so stale values are never mistaken for live ones
    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        @(posedge sys_clk_i); #1;
        cmd_code_o  = code;
        cmd_wdata_o = data;
        cmd_wr_o    = 1'b1;
        @(posedge sys_clk_i); #1;
        cmd_wr_o    = 1'b0;
        cmd_code_o  = ~code;
        cmd_wdata_o = ~data;
    endtask

    task automatic rd(input logic [7:0] code, output logic [7:0] data);
        @(posedge sys_clk_i); #1;
        cmd_code_o = code;
        cmd_rd_o   = 1'b1;
        @(posedge sys_clk_i); #1;
        cmd_rd_o   = 1'b0;
        cmd_code_o = ~code;
        data       = cmd_rdata_i;
    endtask

    // Write then read back in the very next cycle
    task automatic wr_rd(input logic [7:0] data, output logic [7:0] back);
        @(posedge sys_clk_i); #1;
        cmd_code_o  = 8'h17;
        cmd_wdata_o = data;
        cmd_wr_o    = 1'b1;
        @(posedge sys_clk_i); #1;
        cmd_wr_o    = 1'b0;
        cmd_rd_o    = 1'b1;
        cmd_wdata_o = ~data;
        @(posedge sys_clk_i); #1;
        cmd_rd_o    = 1'b0;
        cmd_code_o  = 8'hE8;
        back        = cmd_rdata_i;
    endtask

    // Hold the shutdown stream low for 25004 cycles, then write the register
    task automatic go_multi(input logic [7:0] data);
        fast_shutdown_in_o = 1'b0;
        repeat (25004) @(posedge sys_clk_i);
        wr(8'h17, data);
    endtask
endmodule // pgm_host

/* File: dv/pgm_general_mask_test.sv */
`timescale 1ns/1ps

module pgm_general_mask_test;
    logic sys_clk_i, rst_i, wr_s, rd_s, shut_s, lsb_i, clr_i, irq_n, wide, lsb_o, ml, idle_ok, hit;
    logic [7:0] code, wdata, rdata, st, mk, pa, pb, v;
    logic [3:0] cdone, ddone, cflag, dflag;
    logic [15:0] cres, dres;
    int n_errors = 0;
    int num_checks = 0;

    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    pgm_host host (.sys_clk_i(sys_clk_i), .cmd_rdata_i(rdata), .cmd_wr_o(wr_s), .cmd_rd_o(rd_s),
        .cmd_code_o(code), .cmd_wdata_o(wdata), .fast_shutdown_in_o(shut_s));

    pgm_general_mask DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_wr_i(wr_s), .cmd_rd_i(rd_s),
        .cmd_code_i(code), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_hit_o(hit),
        .irq_status_i(st), .irq_mask_i(mk), .irq_n_o(irq_n), .bus_addr_lsb_i(lsb_i),
        .wide_access_sel_o(wide), .bus_addr_lsb_o(lsb_o), .fast_shutdown_in_i(shut_s),
        .multi_level_shutdown_sel_o(ml), .prio_cmd_a_o(pa), .prio_cmd_b_o(pb),
        .shut_idle_ok_o(idle_ok), .class_done_i(cdone), .class_result_i(cres),
        .detect_done_i(ddone), .detect_result_i(dres), .event_clear_i(clr_i),
        .class_event_flag_o(cflag), .detect_event_flag_o(dflag));

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cfg(input logic [7:0] d);
        host.wr(8'h17, d);
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic ev(input bit cls, input logic [3:0] res, input logic exp, input bit keep);
        @(posedge sys_clk_i); #1;
        if (cls) begin
            cres[3:0] = res;
            cdone     = 4'h1;
        end else begin
            dres[3:0] = res;
            ddone     = 4'h1;
        end
        @(posedge sys_clk_i); #1;
        cdone = 4'h0;
        ddone = 4'h0;
        chk("event_flag", {7'h00, cls ? cflag[0] : dflag[0]}, {7'h00, exp});
        if (!keep) begin
            clr_i = 1'b1;
            @(posedge sys_clk_i); #1;
            clr_i = 1'b0;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        host.rd(8'h17, v);
        chk("reset_value", v, 8'h80);
        chk("hit", {7'h00, hit}, 8'h01);
        chk("prio_a", pa, 8'h15);
        chk("prio_b", pb, 8'h15);
        chk("modes", {4'h0, wide, ml, lsb_o, irq_n}, 8'h01);
        chk("idle_reset", {7'h00, idle_ok}, 8'h00);
        host.rd(8'h16, v);
        chk("other_code", v, 8'h00);
        chk("other_hit", {7'h00, hit}, 8'h00);
    endtask

    task automatic t_irq();
        st = 8'h01;
        repeat (2) @(posedge sys_clk_i); #1;
        chk("irq_unmasked", {7'h00, irq_n}, 8'h00);
        mk = 8'h01;
        repeat (2) @(posedge sys_clk_i); #1;
        chk("irq_masked", {7'h00, irq_n}, 8'h01);
        mk = 8'h00;
        ev(1'b1, 4'h6, 1'b1, 1'b1);
        cfg(8'h00);
        chk("irq_gated", {7'h00, irq_n}, 8'h01);
        chk("flag_kept", {4'h0, cflag}, 8'h01);
        cfg(8'h80);
        chk("irq_regate", {7'h00, irq_n}, 8'h00);
        st = 8'h00;
    endtask

    task automatic t_events();
        for (int c = 0; c < 2; c++) begin
            cfg(8'h80);
            ev(c[0], 4'h3, 1'b1, 1'b0);
            ev(c[0], 4'h3, 1'b1, 1'b0);
            cfg(c[0] ? 8'h88 : 8'h84);
            ev(c[0], 4'h3, 1'b0, 1'b0);
            ev(c[0], 4'h9, 1'b1, 1'b0);
            ev(c[0], 4'h9, 1'b0, 1'b0);
        end
    endtask

    task automatic t_wide();
        lsb_i = 1'b1;
        cfg(8'h80);
        repeat (4) @(posedge sys_clk_i); #1;
        chk("addr_narrow", {6'h00, wide, lsb_o}, 8'h01);
        cfg(8'hA0);
        chk("addr_wide", {6'h00, wide, lsb_o}, 8'h02);
        host.wr_rd(8'hC3, v);
        chk("reserved", v, 8'hC3);
        chk("reserved_eff", {5'h00, wide, ml, lsb_o}, 8'h01);
    endtask

    task automatic t_multi();
        host.go_multi(8'h90);
        repeat (2) @(posedge sys_clk_i); #1;
        chk("multi", {6'h00, ml, idle_ok}, 8'h03);
        chk("prio3", pa, 8'h27);
        chk("prio3b", pb, 8'h28);
        cfg(8'h80);
        chk("prio1_a", pa, 8'h15);
        chk("prio1_b", pb, 8'h15);
    endtask

    initial begin
        rst_i = 1'b1;
        {st, mk, cdone, ddone, cres, dres, lsb_i, clr_i} = '0;
        repeat (8) @(posedge sys_clk_i);
        #1 rst_i = 1'b0;
        t_reset();
        t_irq();
        t_events();
        t_wide();
        t_multi();
        results();
    end

    initial begin
        repeat (40000) @(posedge sys_clk_i);
        n_errors++;
        results();
    end
endmodule // pgm_general_mask_test
